/* include/ewc_pkg.sv */
// Purpose: shared constants and types for the eeprom write control block
// Assumes: 8-bit data space, machine clock of 100 MHz
// Notes: offsets, bit positions and timing live only here
package ewc_pkg;
   localparam int EWC_DW = 8;
   localparam int EWC_AW = 8;
   localparam int EWC_EE_AW = 7;
   localparam int EWC_ROW_BYTES = 8;
   localparam int EWC_ROW_AW = 4;
   localparam int EWC_MEM_BYTES = 128;

   // data space map
   localparam logic [7:0] EWC_ADDR_CONTROL = 8'hDF;
   localparam logic [7:0] EWC_ADDR_BANK = 8'hCB;
   localparam logic [7:0] EWC_WIN_LAST = 8'h3F;
   localparam logic [7:0] EWC_BANK_PAGE0 = 8'h01;
   localparam logic [7:0] EWC_BANK_PAGE1 = 8'h02;
   localparam logic [7:0] EWC_BANK_RESET = 8'h00;

   // eeprom_control bit positions
   localparam int EWC_BIT_STANDBY = 6;
   localparam int EWC_BIT_START = 3;
   localparam int EWC_BIT_ROW_WRITE_MODE = 2;
   localparam int EWC_BIT_BUSY = 1;
   localparam int EWC_BIT_PE = 0;

   localparam logic [7:0] EWC_CONTROL_RESET = 8'h00;
   localparam logic [7:0] EWC_ERASED = 8'hFF;
   localparam logic [7:0] EWC_READ_ZERO = 8'h00;
   localparam logic [7:0] EWC_ROW_NONE = 8'h00;

   // programming cycle time
   localparam int EWC_CLK_MHZ = 100;
   localparam int EWC_PROG_TIME_US = 5000;
   localparam int EWC_PROG_CYCLES = EWC_PROG_TIME_US * EWC_CLK_MHZ;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [EWC_AW-1:0] addr;
      logic [EWC_DW-1:0] wdata;
   } ewc_bus_req_t;

   typedef struct packed {
      logic valid;
      logic [EWC_DW-1:0] data;
   } ewc_bus_rsp_t;

   typedef enum {
      st_idle,
      st_prog
   } ewc_state_t;
endpackage

/* hdl/ewc_eeprom_write_control.sv */
// Purpose: data eeprom with its control register, bank select and
//    byte / row programming sequencer
// Assumes: cpu data space access on ref_clk, one request per cycle
// Notes: read data answers one cycle after the read strobe
`timescale 1ns/1ps
module ewc_eeprom_write_control
   import ewc_pkg::*;
#(
   parameter int PROG_CYCLES = EWC_PROG_CYCLES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // data space access from the cpu
   input wire ewc_bus_req_t bus_req,
   output ewc_bus_rsp_t bus_rsp,
   // status
   output logic eeprom_busy,
   output logic eeprom_power_down,
   output logic access_aborted
);
   localparam int CW = $clog2(PROG_CYCLES + 1);
   localparam logic [CW-1:0] CNT_LOAD = CW'(PROG_CYCLES - 1);
   localparam logic [CW-1:0] CNT_ZERO = '0;

   ewc_state_t state, next_state;
   logic [CW-1:0] cnt, next_cnt;
   logic [7:0] bank_select, next_bank_select;
   logic eeprom_standby, next_eeprom_standby;
   logic program_enable, next_program_enable;
   logic parallel_mode_enable, next_parallel_mode_enable;
   logic parallel_start, next_parallel_start;
   logic next_eeprom_busy;
   logic row_valid, next_row_valid;
   logic [EWC_ROW_AW-1:0] row_idx, next_row_idx;
   logic [7:0] row_data [EWC_ROW_BYTES];
   logic [7:0] next_row_data [EWC_ROW_BYTES];
   logic [EWC_ROW_BYTES-1:0] row_loaded, next_row_loaded;
   logic [EWC_EE_AW-1:0] byte_addr, next_byte_addr;
   logic [7:0] byte_data, next_byte_data;
   ewc_bus_rsp_t next_bus_rsp;
   logic next_access_aborted;
   logic [7:0] mem [EWC_MEM_BYTES];

   logic busy;
   logic in_win;
   logic bank_ok;
   logic ee_hit;
   logic wr_ee;
   logic rd_ee;
   logic wr_ctl;
   logic commit;
   logic [EWC_EE_AW-1:0] ee_addr;
   logic [7:0] wd;

   assign busy = (state == st_prog);
   assign in_win = (bus_req.addr <= EWC_WIN_LAST);
   assign bank_ok = (bank_select == EWC_BANK_PAGE0) ||
                    (bank_select == EWC_BANK_PAGE1);
   // page one sits above page zero in the array
   assign ee_addr = {bank_select == EWC_BANK_PAGE1,
                     bus_req.addr[EWC_EE_AW-2:0]};
   assign ee_hit = in_win && bank_ok && !eeprom_standby;
   assign wr_ee = bus_req.wr && ee_hit;
   assign rd_ee = bus_req.rd && ee_hit;
   assign wr_ctl = bus_req.wr && (bus_req.addr == EWC_ADDR_CONTROL);
   assign wd = bus_req.wdata;
   assign commit = busy && (cnt == CNT_ZERO);

   logic mode_flip;
   logic start_ok;
   logic row_match;
   logic row_load;
   logic byte_go;
   logic [7:0] next_mem [EWC_MEM_BYTES];

   // control writes are taken only while idle
   assign mode_flip = wr_ctl && !busy &&
                      (wd[EWC_BIT_ROW_WRITE_MODE] != parallel_mode_enable);
   // start needs enable and mode both already set
   assign start_ok = wr_ctl && !busy && wd[EWC_BIT_START] &&
                     wd[EWC_BIT_ROW_WRITE_MODE] && wd[EWC_BIT_PE] &&
                     parallel_mode_enable && program_enable;
   // first load fixes the row; loads to other rows are dropped
   assign row_match = !row_valid ||
                      (row_idx == ee_addr[EWC_EE_AW-1:3]);
   assign row_load = wr_ee && !busy && program_enable &&
                     parallel_mode_enable && row_match;
   assign byte_go = wr_ee && !busy && program_enable &&
                    !parallel_mode_enable;

   // bank select is always taken, even while busy
   always_comb begin
      next_bank_select = bank_select;
      if (bus_req.wr && (bus_req.addr == EWC_ADDR_BANK)) begin
         next_bank_select = wd;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         bank_select <= EWC_BANK_RESET;
      end else begin
         bank_select <= next_bank_select;
      end
   end

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_eeprom_standby = eeprom_standby;
      next_program_enable = program_enable;
      next_parallel_mode_enable = parallel_mode_enable;
      next_parallel_start = parallel_start;
      // whole-byte write; the busy check keeps a running cycle intact
      if (wr_ctl && !busy) begin
         next_eeprom_standby = wd[EWC_BIT_STANDBY];
         next_program_enable = wd[EWC_BIT_PE];
         next_parallel_mode_enable = wd[EWC_BIT_ROW_WRITE_MODE];
      end
      if (start_ok || byte_go) begin
         next_parallel_start = start_ok;
         next_state = st_prog;
         next_cnt = CNT_LOAD;
      end
      if (busy) begin
         next_cnt = cnt - 1'b1;
         if (commit) begin
            next_cnt = CNT_ZERO;
            next_state = st_idle;
            next_parallel_start = 1'b0;
            next_parallel_mode_enable = 1'b0;
         end
      end
      next_eeprom_busy = (next_state == st_prog);
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= st_idle;
         cnt <= CNT_ZERO;
         eeprom_standby <= EWC_CONTROL_RESET[EWC_BIT_STANDBY];
         program_enable <= EWC_CONTROL_RESET[EWC_BIT_PE];
         parallel_mode_enable <= EWC_CONTROL_RESET[EWC_BIT_ROW_WRITE_MODE];
         parallel_start <= EWC_CONTROL_RESET[EWC_BIT_START];
         eeprom_busy <= EWC_CONTROL_RESET[EWC_BIT_BUSY];
         eeprom_power_down <= EWC_CONTROL_RESET[EWC_BIT_STANDBY];
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         eeprom_standby <= next_eeprom_standby;
         program_enable <= next_program_enable;
         parallel_mode_enable <= next_parallel_mode_enable;
         parallel_start <= next_parallel_start;
         eeprom_busy <= next_eeprom_busy;
         eeprom_power_down <= next_eeprom_standby;
      end
   end

   // row latches: volatile, lost on leaving the mode
   always_comb begin
      next_row_valid = row_valid;
      next_row_idx = row_idx;
      next_row_data = row_data;
      next_row_loaded = row_loaded;
      // entering the mode clears latches, leaving it drops them
      if (mode_flip) begin
         next_row_loaded = EWC_ROW_NONE;
         next_row_valid = 1'b0;
      end
      if (row_load) begin
         next_row_valid = 1'b1;
         next_row_idx = ee_addr[EWC_EE_AW-1:3];
         next_row_data[ee_addr[2:0]] = wd;
         next_row_loaded[ee_addr[2:0]] = 1'b1;
      end
      if (commit) begin
         next_row_loaded = EWC_ROW_NONE;
         next_row_valid = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         row_valid <= 1'b0;
         row_idx <= '0;
         row_loaded <= EWC_ROW_NONE;
         for (int i = 0; i < EWC_ROW_BYTES; i++) begin
            row_data[i] <= EWC_ERASED;
         end
      end else begin
         row_valid <= next_row_valid;
         row_idx <= next_row_idx;
         row_loaded <= next_row_loaded;
         row_data <= next_row_data;
      end
   end

   // single byte latch for byte mode
   always_comb begin
      next_byte_addr = byte_addr;
      next_byte_data = byte_data;
      if (byte_go) begin
         next_byte_addr = ee_addr;
         next_byte_data = wd;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         byte_addr <= '0;
         byte_data <= EWC_ERASED;
      end else begin
         byte_addr <= next_byte_addr;
         byte_data <= next_byte_data;
      end
   end

   always_comb begin
      next_access_aborted = busy && (wr_ee || rd_ee);
      next_bus_rsp.valid = bus_req.rd;
      next_bus_rsp.data = EWC_READ_ZERO;
      if (bus_req.rd && (bus_req.addr == EWC_ADDR_CONTROL)) begin
         // write-only controls read as zero, only busy shows
         next_bus_rsp.data[EWC_BIT_BUSY] = busy;
      end else if (rd_ee && !busy) begin
         next_bus_rsp.data = mem[ee_addr];
      end else if (bus_req.rd && in_win) begin
         // disabled, unmapped or aborted window reads float high
         next_bus_rsp.data = EWC_ERASED;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_rsp <= '0;
         access_aborted <= 1'b0;
      end else begin
         bus_rsp <= next_bus_rsp;
         access_aborted <= next_access_aborted;
      end
   end

   // cell array; reset stands in for the factory erased state
   for (genvar g = 0; g < EWC_MEM_BYTES; g++) begin : g_cell
      localparam logic [EWC_EE_AW-1:0] A = EWC_EE_AW'(g);
      logic hit_row;
      logic hit_byte;
      assign hit_row = parallel_mode_enable &&
                       (row_idx == A[EWC_EE_AW-1:3]) &&
                       row_loaded[A[2:0]];
      assign hit_byte = !parallel_mode_enable && (byte_addr == A);
      always_comb begin
         next_mem[g] = mem[g];
         if (commit && hit_row) begin
            next_mem[g] = row_data[A[2:0]];
         end else if (commit && hit_byte) begin
            next_mem[g] = byte_data;
         end
      end
   end

   // one register process for the array keeps one driver per cell
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < EWC_MEM_BYTES; i++) begin
            mem[i] <= EWC_ERASED;
         end
      end else begin
         mem <= next_mem;
      end
   end
endmodule

/* bench/ewc_eeprom_write_control_props.sv */
// Purpose: port checks for the eeprom write control block
// Assumes: one clock, reset active low
// Notes: busy length is checked with a helper counter
`timescale 1ns/1ps
module ewc_eeprom_write_control_props
   import ewc_pkg::*;
#(
   parameter int PROG_CYCLES = EWC_PROG_CYCLES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // bus and status
   input wire ewc_bus_req_t bus_req,
   input wire ewc_bus_rsp_t bus_rsp,
   input wire logic eeprom_busy,
   input wire logic eeprom_power_down,
   input wire logic access_aborted
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   int cnt;
   int next_cnt;
   logic win;
   logic ctl_wr;
   logic sb_bit;
   assign win = (bus_req.rd || bus_req.wr) && bus_req.addr <= EWC_WIN_LAST;
   assign ctl_wr = bus_req.wr && bus_req.addr == EWC_ADDR_CONTROL;
   assign sb_bit = bus_req.wdata[EWC_BIT_STANDBY];
   always_comb next_cnt = eeprom_busy ? cnt + 1 : 0;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) cnt <= 0;
      else cnt <= next_cnt;
   end
   property p_len; $fell(eeprom_busy) |-> cnt == PROG_CYCLES; endproperty
   a_len: assert property (p_len) else $error("busy length");
   property p_max; eeprom_busy |-> cnt < PROG_CYCLES; endproperty
   a_max: assert property (p_max) else $error("busy too long");
   property p_rise; $rose(eeprom_busy) |-> $past(bus_req.wr); endproperty
   a_rise: assert property (p_rise) else $error("busy cause");
   property p_abort; eeprom_busy && win |=> access_aborted; endproperty
   a_abort: assert property (p_abort) else $error("no abort");
   property p_ctl_busy;
      ctl_wr && eeprom_busy |=> $stable(eeprom_power_down);
   endproperty
   a_ctl_busy: assert property (p_ctl_busy) else $error("ctl busy");
   property p_pd;
      ctl_wr && !eeprom_busy |=> eeprom_power_down == $past(sb_bit);
   endproperty
   a_pd: assert property (p_pd) else $error("standby bit");
   property p_sb_rd;
      eeprom_power_down && !eeprom_busy && win && bus_req.rd
         |=> bus_rsp.data == EWC_ERASED;
   endproperty
   a_sb_rd: assert property (p_sb_rd) else $error("standby read");
   property p_ctl_rd;
      bus_req.rd && bus_req.addr == EWC_ADDR_CONTROL
         |=> bus_rsp.valid && bus_rsp.data[7:2] == 6'h00;
   endproperty
   a_ctl_rd: assert property (p_ctl_rd) else $error("ctl read");
   c_prog: cover property ($fell(eeprom_busy));
   c_abort: cover property (access_aborted);
   c_sb: cover property (eeprom_power_down && bus_req.rd);
endmodule
bind ewc_eeprom_write_control ewc_eeprom_write_control_props #(
   .PROG_CYCLES(PROG_CYCLES)) u_props (.ref_clk(ref_clk), .rst_b(rst_b),
   .bus_req(bus_req), .bus_rsp(bus_rsp), .eeprom_busy(eeprom_busy),
   .eeprom_power_down(eeprom_power_down), .access_aborted(access_aborted));

/* bench/ewc_cpu_model.sv */
// Purpose: cpu side of the data space bus
// Assumes: one request per access, held one cycle
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module ewc_cpu_model
   import ewc_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // data space access
   output ewc_bus_req_t bus_req,
   input wire ewc_bus_rsp_t bus_rsp
);
   initial bus_req = '0;
   task automatic go(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus_req <= {w, !w, a, d};
      @(posedge ref_clk);
      bus_req <= {1'b0, 1'b0, ~a, ~d};
   endtask
   // whole byte writes only, never single bits
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      go(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      go(1'b0, a, 8'h00);
      #1;
      d = bus_rsp.data;
      v = bus_rsp.valid;
   endtask
endmodule

/* bench/testbench.sv */
// Purpose: self-checking bench for the eeprom write control block
// Assumes: short programming time in simulation
// Notes: busy is polled through the control register
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
   num_errors++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench import ewc_pkg::*;;
   localparam logic [7:0] CT = EWC_ADDR_CONTROL;
   localparam logic [7:0] FF = EWC_ERASED;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   ewc_bus_req_t bus_req;
   ewc_bus_rsp_t bus_rsp;
   logic busy;
   logic pd;
   logic abt;
   logic [7:0] d;
   logic v;
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #5 ref_clk = ~ref_clk;
   ewc_eeprom_write_control #(.PROG_CYCLES(10)) i_dut (.ref_clk(ref_clk),
      .rst_b(rst_b), .bus_req(bus_req), .bus_rsp(bus_rsp),
      .eeprom_busy(busy), .eeprom_power_down(pd), .access_aborted(abt));
   ewc_cpu_model cpu (.ref_clk(ref_clk), .bus_req(bus_req),
      .bus_rsp(bus_rsp));
   task finish_test();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // the whole run needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         finish_test();
      end
   end
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      cpu.rd(a, d, v);
      `CHK(v, 1'b1)
      `CHK(d, e)
   endtask
   task automatic busy_is(input logic e);
      @(posedge ref_clk);
      #1;
      `CHK(busy, e)
   endtask
   task automatic idle();
      int n = 0;
      do begin
         cpu.rd(CT, d, v);
         n++;
      end while (d[EWC_BIT_BUSY] && n < 40);
      `CHK(d, EWC_READ_ZERO)
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'b1;
      busy_is(1'b0);
      cpu.wr(EWC_ADDR_BANK, EWC_BANK_PAGE0);
      rchk(8'h05, FF);
      cpu.wr(8'h05, 8'h3C);
      busy_is(1'b0);
      cpu.wr(CT, 8'h01);
      cpu.wr(8'h05, 8'hA5);
      busy_is(1'b1);
      rchk(8'h05, FF);
      `CHK(abt, 1'b1)
      cpu.wr(CT, 8'h41);
      #1;
      `CHK(pd, 1'b0)
      idle();
      rchk(8'h05, 8'hA5);
      cpu.wr(CT, 8'h05);
      cpu.wr(8'h18, 8'h11);
      cpu.wr(8'h1A, 8'h22);
      cpu.wr(8'h20, 8'h44);
      busy_is(1'b0);
      cpu.wr(CT, 8'h0D);
      busy_is(1'b1);
      idle();
      rchk(8'h18, 8'h11);
      rchk(8'h19, FF);
      rchk(8'h1A, 8'h22);
      rchk(8'h20, FF);
      cpu.wr(8'h1C, 8'h77);
      busy_is(1'b1);
      idle();
      rchk(8'h1C, 8'h77);
      cpu.wr(CT, 8'h05);
      cpu.wr(8'h28, 8'h55);
      cpu.wr(CT, 8'h01);
      cpu.wr(CT, 8'h0D);
      busy_is(1'b0);
      cpu.wr(CT, 8'h01);
      rchk(8'h28, FF);
      cpu.wr(EWC_ADDR_BANK, EWC_BANK_PAGE1);
      rchk(8'h05, FF);
      cpu.wr(EWC_ADDR_BANK, EWC_BANK_PAGE0);
      cpu.wr(CT, 8'h40);
      #1;
      `CHK(pd, 1'b1)
      rchk(8'h05, FF);
      finish_test();
   end
endmodule
